// ===== logic/staging_pkg.sv
// Constants and types shared by the pump staging logic
package staging_pkg;
    // ****************************************************
    // Widths
    // ****************************************************
    localparam int FREQ_W = 16; // Frequency in 0.01 Hz steps
    localparam int TIME_W = 16; // Delay and ramp times in 0.1 s steps
    localparam int MIN_W = 16; // Rotation time in minutes

    // ****************************************************
    // Settings encodings
    // ****************************************************
    localparam logic [3:0] APP_MODE_STAGING = 4'h3;
    localparam logic [1:0] ROT_NONE = 2'h0;
    localparam logic [1:0] ROT_AUX = 2'h1;
    localparam logic [1:0] ROT_MAIN = 2'h2;
    localparam logic [2:0] MAX_AUX = 3'h4;
    localparam logic [2:0] MAX_MOTORS = 3'h4; // Outputs usable in mode 2

    // ****************************************************
    // Timing
    // ****************************************************
    localparam int CLK_KHZ = 40000; // 40 MHz control clock
    localparam int TICK_MS = 100; // One delay step is 0.1 s
    localparam int TICK_CYCLES = TICK_MS * CLK_KHZ; // Cycles per ms times ms
    localparam logic [9:0] TICKS_PER_MIN = 10'h258; // 600 steps of 0.1 s

    // ****************************************************
    // Sequencer states
    // ****************************************************
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_REGULATE = 4'h2,
        ST_RAMP_DOWN = 4'h4,
        ST_RAMP_UP = 4'h8
    } stage_state_t;
endpackage : staging_pkg

// ===== logic/delay_timer_if.sv
// Signals between the sequencer and one staging delay timer
`timescale 1ns/1ps
`default_nettype none
interface delay_timer_if;
    import staging_pkg::*;
    logic tick;
    logic cond;
    logic [TIME_W-1:0] limit;
    logic expired;
    modport timer (input tick, input cond, input limit, output expired);
    modport owner (output tick, output cond, output limit, input expired);
endinterface : delay_timer_if
`default_nettype wire

// ===== logic/staging_delay_timer.sv
// Delay timer counting 0.1 s steps while its condition holds
`timescale 1ns/1ps
`default_nettype none
module staging_delay_timer
    import staging_pkg::*;
(
    input wire logic ref_clk, // 40 MHz control clock
    input wire logic reset_n, // Asynchronous reset, active low
    delay_timer_if.timer tmr // Condition, limit and expiry
);
    logic [TIME_W-1:0] elapsed_r;

    // Count up while the condition stands; a lapse starts over from zero
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            elapsed_r <= '0;
        end else if (!tmr.cond) begin
            elapsed_r <= '0; // RQ17
        end else if (tmr.tick && elapsed_r < tmr.limit) begin
            elapsed_r <= elapsed_r + 1'b1;
        end
    end

    // Saturating count, so expiry holds until the condition lapses
    assign tmr.expired = tmr.cond && (elapsed_r >= tmr.limit);
endmodule : staging_delay_timer
`default_nettype wire

// ===== logic/multi_motor_pump_staging.sv
// Auxiliary pump staging, main motor hand-over and motor rotation
// Summary of operation
// RQ1 - Staging runs, and its settings show, only when application mode is 3.
// RQ2 - Auxiliary motors start in rotating output order from the starting selection.
// RQ3 - Auxiliary motors stop in reverse order; the last started stops first.
// RQ4 - The number of running auxiliary motors is readable.
// RQ5 - Start next motor: speed above start frequency, delay done, error small.
// RQ6 - Stop a motor: speed below stop frequency, delay done, error large.
// RQ7 - During a start or stop the main motor leaves PID and ramps.
// RQ8 - On a start the main motor ramps down to stop frequency, decel time.
// RQ9 - On a stop the main motor ramps up to start frequency, accel time.
// RQ10 - Rotation mode 0 always starts at the set motor, never rotates.
// RQ11 - Mode 1 flags rotation when main and aux run time exceeds setting.
// RQ12 - Mode 1: main stop after flag advances starting motor, 4 wraps to 1.
// RQ13 - Mode 2 flags rotation when inverter motor run time exceeds setting.
// RQ14 - Mode 2: inverter drives selected motor, the rest staged circularly.
// RQ15 - Mode 2: stop in rotation condition moves inverter to next motor.
// RQ16 - Auxiliary count setting is 0 to 4; staging never exceeds it.
// RQ17 - Start and stop delays restart when their condition lapses early.
`timescale 1ns/1ps
`default_nettype none
module multi_motor_pump_staging
    import staging_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES // Cycles per 0.1 s step
) (
    input wire logic ref_clk, // 40 MHz control clock
    input wire logic reset_n, // Asynchronous reset, active low
    input wire logic [3:0] app_mode, // Application mode setting
    input wire logic [2:0] aux_motor_count, // Auxiliary motors, 0 to 4
    input wire logic [2:0] starting_aux_select, // Starting motor, 1 to 4
    input wire logic [3:0][FREQ_W-1:0] aux_start_frequency, // Per stage
    input wire logic [3:0][FREQ_W-1:0] aux_stop_frequency, // Per stage
    input wire logic [TIME_W-1:0] aux_start_delay, // 0.1 s steps
    input wire logic [TIME_W-1:0] aux_stop_delay, // 0.1 s steps
    input wire logic [1:0] rotation_mode, // 0 none, 1 aux, 2 main
    input wire logic [MIN_W-1:0] rotation_time, // Minutes
    input wire logic [FREQ_W-1:0] pressure_difference_threshold, // PID units
    input wire logic [TIME_W-1:0] staging_accel_time, // 0.1 s steps
    input wire logic [TIME_W-1:0] staging_decel_time, // 0.1 s steps
    input wire logic [FREQ_W-1:0] main_freq, // Main motor speed
    input wire logic signed [FREQ_W-1:0] pid_error, // Reference - feedback
    input wire logic main_running, // Inverter output running
    output logic staging_enable_r, // Staging active, option group shown
    output logic [3:0] aux_out_r, // Relay 1, relay 2, output one, output two
    output logic [3:0] main_select_r, // Motor on inverter, mode 2 only
    output logic [2:0] running_aux_count_r, // Running auxiliary motors
    output logic rotation_flag_r, // Rotation condition met
    output logic pid_bypass_r, // Main motor on plain ramp
    output logic ramp_up_r, // Ramp direction, high when rising
    output logic [FREQ_W-1:0] ramp_target_r, // Ramp end frequency
    output logic [TIME_W-1:0] ramp_time_r // Ramp time, 0.1 s steps
);
    // ****************************************************
    // Helpers
    // ****************************************************
    // Output index of position k in a circular order of length modulus
    function automatic logic [1:0] slot_out(input logic [2:0] base,
                                            input logic [2:0] k,
                                            input logic [2:0] modulus);
        logic [3:0] s;
        logic [3:0] m;
        s = {1'b0, base} + {1'b0, k};
        m = (modulus == 3'h0) ? 4'h1 : {1'b0, modulus};
        return 2'(s % m);
    endfunction : slot_out

    function automatic logic [FREQ_W-1:0] mag(input logic signed [FREQ_W-1:0] v);
        return v[FREQ_W-1] ? FREQ_W'(-v) : FREQ_W'(v);
    endfunction : mag

    // ****************************************************
    // Settings decode
    // ****************************************************
    logic enable;
    logic mode_main;
    logic [2:0] aux_n;
    logic [2:0] modulus;
    logic [2:0] capacity;
    logic [2:0] offset;
    logic [2:0] sel_base;
    assign enable = (app_mode == APP_MODE_STAGING); // RQ1
    assign mode_main = (rotation_mode == ROT_MAIN);
    // Clamp out-of-range settings rather than stage a missing output
    assign aux_n = (aux_motor_count > MAX_AUX) ? MAX_AUX : aux_motor_count; // RQ16
    assign modulus = mode_main ? ((aux_n + 3'h1 > MAX_MOTORS) ? MAX_MOTORS
                                  : aux_n + 3'h1) : aux_n; // RQ14
    assign capacity = mode_main ? modulus - 3'h1 : aux_n; // RQ16
    assign offset = mode_main ? 3'h1 : 3'h0;
    assign sel_base = (starting_aux_select == 3'h0) ? 3'h0
                      : starting_aux_select - 3'h1;

    // ****************************************************
    // 0.1 s step and run-time minutes
    // ****************************************************
    logic [22:0] tick_cnt_r;
    logic tick_r;
    logic [9:0] min_cnt_r;
    logic [MIN_W-1:0] run_min_r;
    logic run_prev_r;
    logic stop_edge;
    assign stop_edge = run_prev_r && !main_running;

    // Step generator; the long count is a parameter for simulation
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (tick_cnt_r >= 23'(TICK_LEN - 1)) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // Cumulative run time since the last rotation
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            min_cnt_r <= '0;
            run_min_r <= '0;
        end else if (stop_edge && rotation_flag_r) begin
            min_cnt_r <= '0;
            run_min_r <= '0;
        end else if (enable && main_running && tick_r) begin // RQ11 RQ13
            if (min_cnt_r >= TICKS_PER_MIN - 10'h001) begin
                min_cnt_r <= '0;
                if (run_min_r != '1) run_min_r <= run_min_r + 1'b1;
            end else begin
                min_cnt_r <= min_cnt_r + 1'b1;
            end
        end
    end

    // Rotation flag follows the run time; a consuming stop clears the
    // minutes, so the flag falls one edge later instead of sticking
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rotation_flag_r <= 1'b0;
        end else if (!enable || rotation_mode == ROT_NONE) begin
            rotation_flag_r <= 1'b0; // RQ10
        end else begin
            rotation_flag_r <= (run_min_r > rotation_time); // RQ11 RQ13
        end
    end

    // Starting position; follows the setting in mode 0 and while disabled, else held until rotation moves it
    logic [2:0] base_r;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            base_r <= '0;
            run_prev_r <= 1'b0;
        end else begin
            run_prev_r <= main_running;
            if (!enable || rotation_mode == ROT_NONE) begin
                base_r <= sel_base; // RQ10
            end else if (stop_edge && rotation_flag_r) begin
                if (mode_main) begin
                    base_r <= {1'b0, slot_out(base_r, 3'h1, modulus)}; // RQ15
                end else begin
                    base_r <= {1'b0, slot_out(base_r, 3'h1, MAX_AUX)}; // RQ12
                end
            end
        end
    end

    // ****************************************************
    // Start and stop delay timers
    // ****************************************************
    stage_state_t state_r;
    logic err_small;
    logic err_large;
    logic [1:0] next_idx;
    logic [1:0] last_idx;
    assign err_small = mag(pid_error) < pressure_difference_threshold;
    assign err_large = mag(pid_error) > pressure_difference_threshold;
    assign next_idx = running_aux_count_r[1:0];
    assign last_idx = 2'(running_aux_count_r - 3'h1);

    delay_timer_if start_if ();
    delay_timer_if stop_if ();
    assign start_if.tick = tick_r;
    assign start_if.limit = aux_start_delay;
    assign start_if.cond = (state_r == ST_REGULATE) && main_running &&
                           (running_aux_count_r < capacity) &&
                           (main_freq > aux_start_frequency[next_idx]) &&
                           err_small; // RQ5
    assign stop_if.tick = tick_r;
    assign stop_if.limit = aux_stop_delay;
    assign stop_if.cond = (state_r == ST_REGULATE) && main_running &&
                          (running_aux_count_r != 3'h0) &&
                          (main_freq < aux_stop_frequency[last_idx]) &&
                          err_large; // RQ6

    staging_delay_timer u_start_timer (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .tmr(start_if)
    );
    staging_delay_timer u_stop_timer (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .tmr(stop_if)
    );

    // ****************************************************
    // Staging sequencer
    // ****************************************************
    // Aux outputs, count and bypass drop with the main motor: the line must not run unattended
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_OFF;
            aux_out_r <= '0;
            running_aux_count_r <= '0;
            pid_bypass_r <= 1'b0;
            ramp_up_r <= 1'b0;
            ramp_target_r <= '0;
            ramp_time_r <= '0;
        end else if (!enable || !main_running) begin
            state_r <= enable ? ST_REGULATE : ST_OFF;
            aux_out_r <= '0;
            running_aux_count_r <= '0;
            pid_bypass_r <= 1'b0;
        end else begin
            unique case (state_r)
                ST_OFF: begin
                    state_r <= ST_REGULATE;
                end
                ST_REGULATE: begin
                    if (start_if.expired) begin
                        aux_out_r[slot_out(base_r, running_aux_count_r + offset,
                                           modulus)] <= 1'b1; // RQ2 RQ14
                        running_aux_count_r <= running_aux_count_r + 3'h1; // RQ4
                        pid_bypass_r <= 1'b1; // RQ7
                        ramp_up_r <= 1'b0;
                        ramp_target_r <= aux_stop_frequency[next_idx]; // RQ8
                        ramp_time_r <= staging_decel_time; // RQ8
                        state_r <= ST_RAMP_DOWN;
                    end else if (stop_if.expired) begin
                        aux_out_r[slot_out(base_r, 3'(last_idx) + offset,
                                           modulus)] <= 1'b0; // RQ3
                        running_aux_count_r <= running_aux_count_r - 3'h1; // RQ4
                        pid_bypass_r <= 1'b1; // RQ7
                        ramp_up_r <= 1'b1;
                        ramp_target_r <= aux_start_frequency[last_idx]; // RQ9
                        ramp_time_r <= staging_accel_time; // RQ9
                        state_r <= ST_RAMP_UP;
                    end
                end
                ST_RAMP_DOWN: begin
                    if (main_freq <= ramp_target_r) begin
                        pid_bypass_r <= 1'b0;
                        state_r <= ST_REGULATE;
                    end
                end
                ST_RAMP_UP: begin
                    if (main_freq >= ramp_target_r) begin
                        pid_bypass_r <= 1'b0;
                        state_r <= ST_REGULATE;
                    end
                end
                default: begin
                    state_r <= ST_OFF;
                end
            endcase
        end
    end

    // Enable and inverter motor selection
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            staging_enable_r <= 1'b0;
            main_select_r <= '0;
        end else begin
            staging_enable_r <= enable; // RQ1
            main_select_r <= '0;
            if (enable && mode_main) begin
                main_select_r[slot_out(base_r, 3'h0, modulus)] <= 1'b1; // RQ14
            end
        end
    end
endmodule : multi_motor_pump_staging
`default_nettype wire

// ===== verif/staging_checker.sv
// Concurrent checks on the pump staging ports
`timescale 1ns/1ps
`default_nettype none
module staging_checker
    import staging_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic [3:0] app_mode, // Mode
    input wire logic [2:0] aux_motor_count, // Aux count
    input wire logic [1:0] rotation_mode, // Rotation
    input wire logic [3:0][FREQ_W-1:0] aux_start_frequency, // Start
    input wire logic [3:0][FREQ_W-1:0] aux_stop_frequency, // Stop
    input wire logic [TIME_W-1:0] staging_accel_time, // Accel
    input wire logic [TIME_W-1:0] staging_decel_time, // Decel
    input wire logic main_running, // Running
    input wire logic staging_enable_r, // Enable
    input wire logic [3:0] aux_out_r, // Relays
    input wire logic [3:0] main_select_r, // Inverter motor
    input wire logic [2:0] running_aux_count_r, // Count
    input wire logic rotation_flag_r, // Flag
    input wire logic pid_bypass_r, // Bypass
    input wire logic ramp_up_r, // Direction
    input wire logic [FREQ_W-1:0] ramp_target_r, // Target
    input wire logic [TIME_W-1:0] ramp_time_r // Time
);
    // ****************************************************
    // Helpers
    // ****************************************************
    // Tables of the previous edge, matching registered ramp values
    logic [3:0][FREQ_W-1:0] start_q;
    logic [3:0][FREQ_W-1:0] stop_q;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            start_q <= '0;
            stop_q <= '0;
        end else begin
            start_q <= aux_start_frequency;
            stop_q <= aux_stop_frequency;
        end
    end
    // Count 4 wraps to stage 3 in two bits
    logic [1:0] top_stage;
    logic [2:0] cap;
    assign top_stage = running_aux_count_r[1:0] - 2'h1;
    assign cap = (aux_motor_count > MAX_AUX) ? MAX_AUX : aux_motor_count;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence step_up;
        running_aux_count_r > $past(running_aux_count_r);
    endsequence
    sequence step_down;
        running_aux_count_r < $past(running_aux_count_r) &&
            $past(main_running) && main_running;
    endsequence
    // ****************************************************
    // Assertions
    // ****************************************************
    enable_follow_a: assert property (
        1 |=> staging_enable_r == $past(app_mode == APP_MODE_STAGING))
        else $error("Enable does not follow application mode");
    count_match_a: assert property (
        rotation_mode != ROT_MAIN |->
            running_aux_count_r == $countones(aux_out_r))
        else $error("Running count differs from relays");
    count_cap_a: assert property (running_aux_count_r <= cap)
        else $error("More auxiliary motors than allowed");
    start_ramp_a: assert property (
        step_up |-> pid_bypass_r && !ramp_up_r &&
            ramp_target_r == stop_q[top_stage] &&
            ramp_time_r == $past(staging_decel_time))
        else $error("Start ramp wrong");
    stop_ramp_a: assert property (
        step_down |-> pid_bypass_r && ramp_up_r &&
            ramp_target_r == start_q[running_aux_count_r[1:0]] &&
            ramp_time_r == $past(staging_accel_time))
        else $error("Stop ramp wrong");
    one_on_a: assert property (
        step_up |-> $countones(aux_out_r & ~$past(aux_out_r)) == 1)
        else $error("Start did not add one relay");
    one_off_a: assert property (
        step_down |-> $countones($past(aux_out_r) & ~aux_out_r) == 1 &&
            (aux_out_r & ~$past(aux_out_r)) == 4'h0)
        else $error("Stop did not drop one relay");
    ramp_hold_a: assert property (
        pid_bypass_r && main_running && app_mode == APP_MODE_STAGING
            |=> running_aux_count_r == $past(running_aux_count_r))
        else $error("Staging changed during a ramp");
    main_select_a: assert property (
        1 |=> main_select_r == 4'h0 ||
            ($past(rotation_mode) == ROT_MAIN && $onehot(main_select_r)))
        else $error("Inverter motor select wrong");
    no_rotate_a: assert property (
        rotation_mode == ROT_NONE |=> !rotation_flag_r)
        else $error("Rotation flagged in mode none");
endmodule : staging_checker
bind multi_motor_pump_staging staging_checker i_checker (.*);
`default_nettype wire

// ===== verif/pump_plant.sv
// Main motor speed model answering the staging ramps
`timescale 1ns/1ps
`default_nettype none
module pump_plant
    import staging_pkg::*;
#(
    parameter logic [FREQ_W-1:0] SLEW = 16'h0100 // Speed change per cycle
) (
    input wire logic ref_clk, // Control clock
    input wire logic reset_n, // Reset, active low
    input wire logic ramp_active, // Main motor on plain ramp
    input wire logic [FREQ_W-1:0] ramp_target, // Ramp end frequency
    input wire logic [FREQ_W-1:0] demand, // Speed the PID asks for
    output logic [FREQ_W-1:0] main_freq // Main motor speed
);
    // Slews toward the ramp end, so the hand-back is never instant
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            main_freq <= 16'h0000;
        end else if (!ramp_active) begin
            main_freq <= demand;
        end else if (main_freq > ramp_target + SLEW) begin
            main_freq <= main_freq - SLEW;
        end else if (main_freq + SLEW < ramp_target) begin
            main_freq <= main_freq + SLEW;
        end else begin
            main_freq <= ramp_target;
        end
    end
endmodule : pump_plant
`default_nettype wire

// ===== verif/test_multi_motor_pump_staging.sv
// Self-checking bench for the pump staging block
`timescale 1ns/1ps
`default_nettype none
module test_multi_motor_pump_staging
    import staging_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] app_mode = 4'h0;
    logic [2:0] aux_n = 3'h3;
    logic [2:0] sel = 3'h2;
    logic [3:0][FREQ_W-1:0] start_f = '0;
    logic [3:0][FREQ_W-1:0] stop_f = '0;
    logic [TIME_W-1:0] dly_on = '0, dly_off = '0, acc_t = '0, dec_t = '0;
    logic [1:0] rot = ROT_NONE;
    logic [MIN_W-1:0] rot_time = '0;
    logic [FREQ_W-1:0] demand = 16'h0c00;
    logic signed [FREQ_W-1:0] err = '0;
    logic run = 1'b0;
    wire logic [FREQ_W-1:0] main_freq;
    logic en, flag, byp, rup;
    logic [3:0] aux_out, msel;
    logic [2:0] cnt;
    logic [FREQ_W-1:0] tgt;
    logic [TIME_W-1:0] rtime;
    int bad_count = 0;
    int n_tests = 0;
    initial forever #12.5 ref_clk = ~ref_clk;
    multi_motor_pump_staging #(.TICK_LEN(4)) i_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .app_mode(app_mode),
        .aux_motor_count(aux_n), .starting_aux_select(sel),
        .aux_start_frequency(start_f), .aux_stop_frequency(stop_f),
        .aux_start_delay(dly_on), .aux_stop_delay(dly_off),
        .rotation_mode(rot), .rotation_time(rot_time),
        .pressure_difference_threshold(16'h0100),
        .staging_accel_time(acc_t), .staging_decel_time(dec_t),
        .main_freq(main_freq), .pid_error(err), .main_running(run),
        .staging_enable_r(en), .aux_out_r(aux_out), .main_select_r(msel),
        .running_aux_count_r(cnt), .rotation_flag_r(flag),
        .pid_bypass_r(byp), .ramp_up_r(rup), .ramp_target_r(tgt),
        .ramp_time_r(rtime));
    pump_plant i_plant (.ref_clk(ref_clk), .reset_n(reset_n),
        .ramp_active(byp), .ramp_target(tgt), .demand(demand),
        .main_freq(main_freq));
    // ****************************************************
    // Tasks
    // ****************************************************
    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // A wait that ran out ends the run
    task automatic guard(input logic ok);
        if (ok !== 1'b1) begin
            bad_count++;
            test_done();
        end
    endtask : guard
    function automatic logic [3:0] bit_at(int base, int k, int m);
        return 4'(1 << ((base + k) % m));
    endfunction : bit_at
    // Fresh stage tables; start at or above 0x1000, stop below 0x0800
    task automatic shuffle();
        for (int j = 0; j < 4; j++) begin
            start_f[j] <= 16'h1000 + 16'($urandom % 4096);
            stop_f[j] <= 16'h0400 + 16'($urandom % 1024);
        end
        dly_on <= 16'($urandom % 4);
        dly_off <= 16'($urandom % 4);
        acc_t <= 16'($urandom);
        dec_t <= 16'($urandom);
    endtask : shuffle
    // One start or stop, then the hand-back to PID
    task automatic step(input logic up, input logic [3:0] bits);
        logic [2:0] k;
        int i;
        k = cnt;
        @(posedge ref_clk);
        demand <= up ? start_f[k[1:0]] + 16'h1 : stop_f[k[1:0] - 2'h1] - 16'h1;
        err <= up ? 16'sh0000 : 16'sh0200;
        for (i = 0; i < 400 && cnt === k; i++) @(negedge ref_clk);
        guard(cnt !== k);
        @(posedge ref_clk);
        demand <= 16'h0c00;
        err <= 16'sh0000;
        for (i = 0; i < 400 && byp !== 1'b0; i++) @(negedge ref_clk);
        guard(byp === 1'b0);
        check(4'(cnt), up ? 4'(k + 3'h1) : 4'(k - 3'h1));
        check(aux_out, bits);
    endtask : step
    task automatic await_flag();
        int i;
        for (i = 0; i < 3000 && flag !== 1'b1; i++) @(negedge ref_clk);
        guard(flag === 1'b1);
    endtask : await_flag
    // ****************************************************
    // Scenarios
    // ****************************************************
    initial begin
        logic [3:0] exp_out;
        void'($urandom(10));
        shuffle();
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        app_mode <= 4'($urandom % 3);
        demand <= 16'h3000;
        run <= 1'b1;
        repeat (30) @(negedge ref_clk);
        check(4'(en), 4'h0);
        check(4'(cnt), 4'h0);
        @(posedge ref_clk);
        app_mode <= APP_MODE_STAGING;
        err <= ($urandom % 2) ? 16'sh0200 : -16'sh0200;
        repeat (40) @(negedge ref_clk);
        check(4'(en), 4'h1);
        check(4'(cnt), 4'h0);
        // Error small for two steps only, then one edge large: no start
        dly_on <= 16'h0003;
        for (int j = 0; j < 6; j++) begin
            @(posedge ref_clk);
            err <= 16'sh0000;
            repeat (8) @(posedge ref_clk);
            err <= 16'sh0200;
        end
        @(negedge ref_clk);
        check(4'(cnt), 4'h0);
        exp_out = 4'h0;
        for (int k = 0; k < 3; k++) begin
            exp_out = exp_out | bit_at(1, k, 3);
            step(1'b1, exp_out);
        end
        @(posedge ref_clk);
        demand <= 16'h3000;
        repeat (40) @(negedge ref_clk);
        check(4'(cnt), 4'h3);
        for (int k = 2; k >= 0; k--) begin
            exp_out = exp_out & ~bit_at(1, k, 3);
            step(1'b0, exp_out);
        end
        @(posedge ref_clk);
        run <= 1'b0;
        aux_n <= 3'h4;
        sel <= 3'h4;
        shuffle();
        @(posedge ref_clk);
        run <= 1'b1;
        // Mode 1 keeps its start motor, so it is taken in mode 0 first
        rot <= ROT_AUX;
        step(1'b1, 4'h8);
        await_flag();
        check(4'(flag), 4'h1);
        @(posedge ref_clk);
        run <= 1'b0;
        repeat (3) @(negedge ref_clk);
        check(4'(flag), 4'h0);
        @(posedge ref_clk);
        run <= 1'b1;
        step(1'b1, 4'h1);
        @(posedge ref_clk);
        run <= 1'b0;
        rot <= ROT_NONE;
        aux_n <= 3'h3;
        sel <= 3'h2;
        repeat (2) @(posedge ref_clk);
        rot <= ROT_MAIN;
        run <= 1'b1;
        repeat (3) @(negedge ref_clk);
        check(msel, 4'h2);
        step(1'b1, 4'h4);
        await_flag();
        check(4'(flag), 4'h1);
        @(posedge ref_clk);
        run <= 1'b0;
        repeat (3) @(posedge ref_clk);
        run <= 1'b1;
        repeat (3) @(negedge ref_clk);
        check(msel, 4'h4);
        step(1'b1, 4'h8);
        test_done();
    end
endmodule : test_multi_motor_pump_staging
`default_nettype wire
